/* rtl/pes_pkg.sv */
// constants, register map and types of the completion-error sideband controller
package pes_pkg;

   // clock and timing
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned CPL_TIMEOUT_MS = 50;
   localparam int unsigned CPL_TIMEOUT_CYCLES = CPL_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned CPL_ERR_SPACING = 8;
   localparam logic [2:0] GAP_LOAD = 3'(CPL_ERR_SPACING - 1);

   // software register offsets
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_MSI_CFG = 8'h04;
   localparam logic [7:0] REG_PENDING = 8'h08;
   localparam logic [7:0] REG_HDR0 = 8'h0C;
   localparam logic [7:0] REG_HDR3 = 8'h18;
   localparam logic [7:0] REG_STATUS = 8'h1C;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h20;
   localparam logic [7:0] REG_IRQ_CLEAR = 8'h24;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h28;

   // command register fields
   localparam int unsigned CMD_VEC_LSB = 0;
   localparam int unsigned CMD_FUNC_LSB = 8;
   // msi / timeout config fields
   localparam int unsigned MSI_AER_LSB = 0;
   localparam int unsigned MSI_PEX_LSB = 8;
   localparam int unsigned TO_EN_BIT = 16;
   localparam int unsigned TO_FATAL_BIT = 17;
   // status register fields
   localparam int unsigned STS_BUSY_BIT = 0;
   localparam int unsigned STS_INTX_LSB = 1;
   localparam int unsigned STS_SERR_BIT = 5;

   // completion-error vector bits
   localparam int unsigned CE_W = 7;
   localparam int unsigned CE_TIMEOUT_COR = 0;
   localparam int unsigned CE_TIMEOUT_UNC = 1;
   localparam int unsigned CE_CPL_ABORT = 2;
   localparam int unsigned CE_UNEXPECTED = 3;
   localparam int unsigned CE_UR_POSTED = 4;
   localparam int unsigned CE_UR_NONPOSTED = 5;
   localparam int unsigned CE_LOG_HDR = 6;

   // header logging over the management port
   localparam logic [11:0] LMI_HDR_BASE = 12'h081C;
   localparam logic [11:0] LMI_HDR_STEP = 12'h0004;
   localparam logic [1:0] HDR_LAST = 2'h3;

   // interrupt status bits
   localparam int unsigned IRQ_W = 5;
   localparam int unsigned IRQ_SERR = 0;
   localparam int unsigned IRQ_INTX = 1;
   localparam int unsigned IRQ_DONE = 2;
   localparam int unsigned IRQ_REFUSED = 3;
   localparam int unsigned IRQ_TIMEOUT = 4;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_HDR_RD,
      ST_HDR_WR,
      ST_HDR_ACK,
      ST_FIRE
   } pes_state_t;

   // index of the lowest set bit of a function vector
   function automatic logic [2:0] lowest_set(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

endpackage

/* rtl/pes_hdr_mem.sv */
// four-word store for the logged error header, registered read
`timescale 1ns/1ps
module pes_hdr_mem (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [1:0] wr_addr,
   input wire logic [31:0] wr_data,
   input wire logic rd_en,
   input wire logic [1:0] rd_addr,
   output logic [31:0] rd_data
);

   logic [31:0] mem [0:3];

   // write port
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // read data held in a register
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rd_data <= 32'h0000_0000;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

/* rtl/pes_ctrl.sv */
// application-side controller for root-port interrupts and completion-error reporting
// Contract
// - controller supplies the 5-bit error-reporting msi number
// - controller supplies the 5-bit power-management msi number
// - each completion error is reported by a one-cycle pulse of its bit
// - correctable 50 ms completion timeout reported on bit 0
// - uncorrectable 50 ms completion timeout reported on bit 1
// - completer abort bit follows the abort completion the application already sent
// - bit 3 reports unexpected completions not caught inside the core
// - bit 4 makes a posted request unsupported
// - bit 5 follows an unsupported-request completion for a non-posted request
// - the application itself builds every rejecting completion
// - log-header bit needs the four header words written first at 0x81C..0x828
// - reports at least 8 cycles apart, function number in the same cycle
// - one level completion-pending bit per function, bit 0 is function 0
`timescale 1ns/1ps
module pes_ctrl #(
   parameter int unsigned TIMEOUT_CYCLES = pes_pkg::CPL_TIMEOUT_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   input wire logic [3:0] int_status,
   input wire logic serr_out,
   output logic [4:0] aer_msi_num,
   output logic [4:0] pex_msi_num,
   output logic [6:0] cpl_err,
   output logic [2:0] cpl_err_func,
   output logic [7:0] cpl_pending,
   output logic [11:0] lmi_addr,
   output logic [31:0] lmi_din,
   output logic lmi_wr,
   input wire logic lmi_ack
);

   // sequencer state
   pes_pkg::pes_state_t state_r;
   logic [6:0] req_vec_r;
   logic [2:0] req_func_r;
   logic [1:0] hdr_idx_r;
   logic [2:0] gap_r;
   // timeout timer
   logic to_en_r;
   logic to_fatal_r;
   logic [31:0] to_cnt_r;
   logic to_req_r;
   logic to_done_r;
   // interrupt status, enables and events
   logic [3:0] intx_prev_r;
   logic [pes_pkg::IRQ_W-1:0] irq_sts_r;
   logic [pes_pkg::IRQ_W-1:0] irq_en_r;
   logic [pes_pkg::IRQ_W-1:0] irq_set;
   logic [pes_pkg::IRQ_W-1:0] irq_clr;
   // header read data and decoded strobes
   logic [31:0] hdr_q;
   logic cmd_wr;
   logic hdr_wr;
   logic cmd_ok;
   logic to_hit;
   logic fire;
   logic [1:0] hdr_wr_idx;
   logic [7:0] hdr_off;

   // register write decode
   assign cmd_wr = reg_wr && (reg_addr == pes_pkg::REG_CMD);
   assign hdr_wr = reg_wr && (reg_addr >= pes_pkg::REG_HDR0) && (reg_addr <= pes_pkg::REG_HDR3);
   assign hdr_off = reg_addr - pes_pkg::REG_HDR0;
   assign hdr_wr_idx = hdr_off[3:2];
   assign irq_clr = (reg_wr && reg_addr == pes_pkg::REG_IRQ_CLEAR) ?
                    reg_wdata[pes_pkg::IRQ_W-1:0] : '0;

   // a command is taken only when idle and it reports something
   assign cmd_ok = cmd_wr && (state_r == pes_pkg::ST_IDLE) &&
                   (reg_wdata[pes_pkg::CMD_VEC_LSB +: pes_pkg::CE_W] != 7'h00);
   // a ready report leaves only once the spacing counter has run out
   assign fire = (state_r == pes_pkg::ST_FIRE) && (gap_r == 3'h0);
   // timer expiry, at most once per pending write
   assign to_hit = to_en_r && !to_done_r && (cpl_pending != 8'h00) &&
                   (to_cnt_r == 32'(TIMEOUT_CYCLES - 1));

   // header words, replayed to the management port before a logged report
   pes_hdr_mem u_hdr_mem (
      .core_clk(core_clk),
      .reset(reset),
      .wr_en(hdr_wr),
      .wr_addr(hdr_wr_idx),
      .wr_data(reg_wdata),
      .rd_en(state_r == pes_pkg::ST_HDR_RD),
      .rd_addr(hdr_idx_r),
      .rd_data(hdr_q)
   );

   // report sequencer
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_r <= pes_pkg::ST_IDLE;
         req_vec_r <= 7'h00;
         req_func_r <= 3'h0;
         hdr_idx_r <= 2'h0;
      end else begin
         case (state_r)
            pes_pkg::ST_IDLE: begin
               hdr_idx_r <= 2'h0;
               // software must already have sent any abort or UR completion
               if (cmd_ok) begin
                  req_vec_r <= reg_wdata[pes_pkg::CMD_VEC_LSB +: pes_pkg::CE_W];
                  req_func_r <= reg_wdata[pes_pkg::CMD_FUNC_LSB +: 3];
                  if (reg_wdata[pes_pkg::CMD_VEC_LSB + pes_pkg::CE_LOG_HDR]) begin
                     state_r <= pes_pkg::ST_HDR_RD;
                  end else begin
                     state_r <= pes_pkg::ST_FIRE;
                  end
               end else if (to_req_r) begin
                  // timeout report: correctable or not, per config
                  req_vec_r <= 7'h00;
                  req_vec_r[pes_pkg::CE_TIMEOUT_UNC] <= to_fatal_r;
                  req_vec_r[pes_pkg::CE_TIMEOUT_COR] <= !to_fatal_r;
                  req_func_r <= pes_pkg::lowest_set(cpl_pending);
                  state_r <= pes_pkg::ST_FIRE;
               end
            end
            pes_pkg::ST_HDR_RD: begin
               state_r <= pes_pkg::ST_HDR_WR;
            end
            pes_pkg::ST_HDR_WR: begin
               state_r <= pes_pkg::ST_HDR_ACK;
            end
            pes_pkg::ST_HDR_ACK: begin
               if (lmi_ack) begin
                  hdr_idx_r <= hdr_idx_r + 2'h1;
                  if (hdr_idx_r == pes_pkg::HDR_LAST) begin
                     state_r <= pes_pkg::ST_FIRE;
                  end else begin
                     state_r <= pes_pkg::ST_HDR_RD;
                  end
               end
            end
            pes_pkg::ST_FIRE: begin
               if (fire) begin
                  state_r <= pes_pkg::ST_IDLE;
               end
            end
            default: begin
               state_r <= pes_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // management port writes of the header, first word to the lowest address
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         lmi_addr <= 12'h000;
         lmi_din <= 32'h0000_0000;
         lmi_wr <= 1'b0;
      end else begin
         lmi_wr <= 1'b0;
         if (state_r == pes_pkg::ST_HDR_WR) begin
            lmi_addr <= pes_pkg::LMI_HDR_BASE + 12'(hdr_idx_r) * pes_pkg::LMI_HDR_STEP;
            lmi_din <= hdr_q;
            lmi_wr <= 1'b1;
         end
      end
   end

   // one-cycle error pulse with its function number, spaced by the gap counter
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cpl_err <= 7'h00;
         cpl_err_func <= 3'h0;
         gap_r <= 3'h0;
      end else begin
         cpl_err <= 7'h00;
         if (fire) begin
            cpl_err <= req_vec_r;
            cpl_err_func <= req_func_r;
            gap_r <= pes_pkg::GAP_LOAD;
         end else if (gap_r != 3'h0) begin
            gap_r <= gap_r - 3'h1;
         end
      end
   end

   // msi numbers, pending levels and timeout config
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         aer_msi_num <= 5'h00;
         pex_msi_num <= 5'h00;
         to_en_r <= 1'b0;
         to_fatal_r <= 1'b0;
         cpl_pending <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == pes_pkg::REG_MSI_CFG) begin
            aer_msi_num <= reg_wdata[pes_pkg::MSI_AER_LSB +: 5];
            pex_msi_num <= reg_wdata[pes_pkg::MSI_PEX_LSB +: 5];
            to_en_r <= reg_wdata[pes_pkg::TO_EN_BIT];
            to_fatal_r <= reg_wdata[pes_pkg::TO_FATAL_BIT];
         end
         if (reg_addr == pes_pkg::REG_PENDING) begin
            cpl_pending <= reg_wdata[7:0];
         end
      end
   end

   // completion timeout timer, armed while any function is pending
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         to_cnt_r <= 32'h0000_0000;
         to_req_r <= 1'b0;
         to_done_r <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == pes_pkg::REG_PENDING) begin
            to_done_r <= 1'b0;
            to_cnt_r <= 32'h0000_0000;
         end else if (!to_en_r || to_done_r || cpl_pending == 8'h00) begin
            to_cnt_r <= 32'h0000_0000;
         end else if (to_hit) begin
            to_cnt_r <= 32'h0000_0000;
            to_done_r <= 1'b1;
         end else begin
            to_cnt_r <= to_cnt_r + 32'h0000_0001;
         end
         // expiry queues a report until the sequencer is idle
         if (to_hit) begin
            to_req_r <= 1'b1;
         end else if (state_r == pes_pkg::ST_IDLE && !cmd_ok) begin
            to_req_r <= 1'b0;
         end
      end
   end

   // interrupt events; device sideband is on this same clock, no synchroniser
   always_comb begin
      irq_set = '0;
      irq_set[pes_pkg::IRQ_SERR] = serr_out;
      irq_set[pes_pkg::IRQ_INTX] = |(int_status & ~intx_prev_r);
      irq_set[pes_pkg::IRQ_DONE] = fire;
      irq_set[pes_pkg::IRQ_REFUSED] = cmd_wr && !cmd_ok;
      irq_set[pes_pkg::IRQ_TIMEOUT] = to_hit;
   end

   // sticky status, set wins over clear, enable gates the level output
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irq_sts_r <= '0;
         irq_en_r <= '0;
         intx_prev_r <= 4'h0;
         irq <= 1'b0;
      end else begin
         intx_prev_r <= int_status;
         irq_sts_r <= (irq_sts_r & ~irq_clr) | irq_set;
         if (reg_wr && reg_addr == pes_pkg::REG_IRQ_ENABLE) begin
            irq_en_r <= reg_wdata[pes_pkg::IRQ_W-1:0];
         end
         irq <= |(((irq_sts_r & ~irq_clr) | irq_set) & irq_en_r);
      end
   end

   // read data, valid the cycle after the read strobe
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= 32'h0000_0000;
         case (reg_addr)
            pes_pkg::REG_MSI_CFG: begin
               reg_rdata[pes_pkg::MSI_AER_LSB +: 5] <= aer_msi_num;
               reg_rdata[pes_pkg::MSI_PEX_LSB +: 5] <= pex_msi_num;
               reg_rdata[pes_pkg::TO_EN_BIT] <= to_en_r;
               reg_rdata[pes_pkg::TO_FATAL_BIT] <= to_fatal_r;
            end
            pes_pkg::REG_PENDING: begin
               reg_rdata[7:0] <= cpl_pending;
            end
            pes_pkg::REG_STATUS: begin
               reg_rdata[pes_pkg::STS_BUSY_BIT] <= (state_r != pes_pkg::ST_IDLE);
               reg_rdata[pes_pkg::STS_INTX_LSB +: 4] <= int_status;
               reg_rdata[pes_pkg::STS_SERR_BIT] <= serr_out;
            end
            pes_pkg::REG_IRQ_STATUS: begin
               reg_rdata[pes_pkg::IRQ_W-1:0] <= irq_sts_r;
            end
            pes_pkg::REG_IRQ_ENABLE: begin
               reg_rdata[pes_pkg::IRQ_W-1:0] <= irq_en_r;
            end
            default: begin
               reg_rdata <= 32'h0000_0000;
            end
         endcase
      end
   end

endmodule

/* verif/pes_ctrl_checker.sv */
// concurrent checks on the ports of the completion-error sideband controller
`timescale 1ns/1ps
module pes_ctrl_checker (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [3:0] int_status,
   input wire logic serr_out,
   input wire logic [4:0] aer_msi_num,
   input wire logic [4:0] pex_msi_num,
   input wire logic [6:0] cpl_err,
   input wire logic [2:0] cpl_err_func,
   input wire logic [7:0] cpl_pending,
   input wire logic [11:0] lmi_addr,
   input wire logic lmi_wr
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   logic [2:0] hdr_cnt_r;
   // header words written since the last report
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         hdr_cnt_r <= 3'h0;
      end else if (cpl_err != 7'h00) begin
         hdr_cnt_r <= 3'h0;
      end else if (lmi_wr) begin
         hdr_cnt_r <= hdr_cnt_r + 3'h1;
      end
   end
   sequence s_report;
      cpl_err != 7'h00;
   endsequence
   sequence s_quiet;
      (cpl_err == 7'h00) [*7];
   endsequence
   a_err_single_pulse: assert property (s_report |=> cpl_err == 7'h00)
      else $error("report pulse longer than one cycle");
   a_err_spacing_gap: assert property (s_report |=> s_quiet)
      else $error("reports closer than eight cycles");
   a_func_with_err: assert property ($changed(cpl_err_func) |-> cpl_err != 7'h00)
      else $error("function number moved without a report");
   a_lmi_single_pulse: assert property (lmi_wr |=> !lmi_wr)
      else $error("header write strobe too long");
   a_lmi_addr_range: assert property (lmi_wr |-> lmi_addr inside {12'h081C, 12'h0820,
      12'h0824, 12'h0828})
      else $error("header write outside the header words");
   a_hdr_before_log: assert property (cpl_err[6] |-> hdr_cnt_r == 3'h4)
      else $error("log-header report without four header words");
   a_msi_num_follow: assert property (reg_wr && reg_addr == pes_pkg::REG_MSI_CFG |=>
      aer_msi_num == $past(reg_wdata[4:0]) && pex_msi_num == $past(reg_wdata[12:8]))
      else $error("msi numbers do not follow the config write");
   a_pending_follow: assert property (reg_wr && reg_addr == pes_pkg::REG_PENDING |=>
      cpl_pending == $past(reg_wdata[7:0]))
      else $error("pending bits do not follow the write");
   a_status_live_read: assert property (reg_rd && reg_addr == pes_pkg::REG_STATUS |=>
      reg_rdata[5:1] == $past({serr_out, int_status}))
      else $error("status read does not show live interrupt lines");
endmodule
bind pes_ctrl pes_ctrl_checker i_chk (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .int_status(int_status), .serr_out(serr_out), .aer_msi_num(aer_msi_num),
   .pex_msi_num(pex_msi_num), .cpl_err(cpl_err), .cpl_err_func(cpl_err_func),
   .cpl_pending(cpl_pending), .lmi_addr(lmi_addr), .lmi_wr(lmi_wr));

/* verif/pes_dev_model.sv */
// behavioural model of the core side: interrupt lines, system error, header port
`timescale 1ns/1ps
module pes_dev_model (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [3:0] int_lvl,
   input wire logic serr_req,
   input wire logic [3:0] ack_wait,
   input wire logic [6:0] cpl_err,
   input wire logic [2:0] cpl_err_func,
   input wire logic [11:0] lmi_addr,
   input wire logic [31:0] lmi_din,
   input wire logic lmi_wr,
   output logic [3:0] int_status,
   output logic serr_out,
   output logic lmi_ack
);
   int rep_cnt;
   logic [6:0] last_vec;
   logic [2:0] last_func;
   logic [31:0] hdr [4];
   logic [3:0] wait_r;
   logic pend_r;
   // legacy lines and one-cycle system error, all on the application clock
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         int_status <= 4'h0;
         serr_out <= 1'b0;
      end else begin
         int_status <= int_lvl;
         serr_out <= serr_req && !serr_out;
      end
   end
   // header store with a slow acknowledge
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         lmi_ack <= 1'b0;
         pend_r <= 1'b0;
         wait_r <= 4'h0;
      end else begin
         lmi_ack <= 1'b0;
         if (lmi_wr) begin
            hdr[(lmi_addr - 12'h081C) >> 2] <= lmi_din;
            wait_r <= ack_wait;
            pend_r <= 1'b1;
         end else if (pend_r && wait_r == 4'h0) begin
            lmi_ack <= 1'b1;
            pend_r <= 1'b0;
         end else if (pend_r) begin
            wait_r <= wait_r - 4'h1;
         end
      end
   end
   // each report counted, with its vector and function kept
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rep_cnt <= 0;
         last_vec <= 7'h00;
         last_func <= 3'h0;
      end else if (cpl_err != 7'h00) begin
         rep_cnt <= rep_cnt + 1;
         last_vec <= cpl_err;
         last_func <= cpl_err_func;
      end
   end
endmodule

/* verif/pes_ctrl_tb.sv */
// self-checking bench for the completion-error sideband controller
`timescale 1ns/1ps
module pes_ctrl_tb;
   logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, serr_req = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000, rd_v;
   logic [3:0] int_lvl = 4'h0, ack_wait = 4'h0, int_status;
   logic [31:0] reg_rdata, lmi_din;
   logic irq, serr_out, lmi_wr, lmi_ack;
   logic [4:0] aer_msi_num, pex_msi_num;
   logic [6:0] cpl_err;
   logic [2:0] cpl_err_func;
   logic [7:0] cpl_pending;
   logic [11:0] lmi_addr;
   int miscompares = 0, num_checks = 0, nrep = 0;
   always #12.5 core_clk = ~core_clk;
   pes_ctrl #(.TIMEOUT_CYCLES(20)) i_dut (.core_clk(core_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .int_status(int_status), .serr_out(serr_out),
      .aer_msi_num(aer_msi_num), .pex_msi_num(pex_msi_num), .cpl_err(cpl_err),
      .cpl_err_func(cpl_err_func), .cpl_pending(cpl_pending), .lmi_addr(lmi_addr),
      .lmi_din(lmi_din), .lmi_wr(lmi_wr), .lmi_ack(lmi_ack));
   pes_dev_model i_dev (.core_clk(core_clk), .reset(reset), .int_lvl(int_lvl),
      .serr_req(serr_req), .ack_wait(ack_wait), .cpl_err(cpl_err), .cpl_err_func(cpl_err_func),
      .lmi_addr(lmi_addr), .lmi_din(lmi_din), .lmi_wr(lmi_wr), .int_status(int_status),
      .serr_out(serr_out), .lmi_ack(lmi_ack));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // wait for the next report at the model, then compare count, vector and function
   task automatic rep(input logic [6:0] v, input logic [2:0] f);
      nrep++;
      for (int k = 0; k < 400 && i_dev.rep_cnt != nrep; k++) @(posedge core_clk);
      #1 chk({i_dev.rep_cnt[21:0], i_dev.last_func, i_dev.last_vec}, {nrep[21:0], f, v});
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #500000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rd(pes_pkg::REG_IRQ_STATUS);
      chk(rd_v, 32'h0000_0000);
      rd(8'h40); // unmapped place
      chk(rd_v, 32'h0000_0000);
      wr(pes_pkg::REG_MSI_CFG, 32'h0000_0A15);
      rd(pes_pkg::REG_MSI_CFG);
      chk(rd_v, 32'h0000_0A15);
      chk({22'h0, pex_msi_num, aer_msi_num}, 32'h0000_0155);
      // report codes bits 0 to 5 (not log-header), back to back, one per function
      for (int i = 0; i < 6; i++) begin
         wr(pes_pkg::REG_CMD, 32'(i << 8) | 32'(1 << i));
         rep(7'(1 << i), 3'(i));
      end
      rd(pes_pkg::REG_IRQ_STATUS);
      chk(rd_v & 32'h0000_0004, 32'h0000_0004);
      // header path with slow acks, a command while busy is refused
      for (int w = 0; w < 4; w++) wr(8'(8'h0C + 4 * w), 32'hA000_0000 + 32'(w));
      ack_wait <= 4'h3;
      wr(pes_pkg::REG_CMD, 32'h0000_0244);
      wr(pes_pkg::REG_CMD, 32'h0000_0001);
      rep(7'h44, 3'h2);
      for (int w = 0; w < 4; w++) chk(i_dev.hdr[w], 32'hA000_0000 + 32'(w));
      rd(pes_pkg::REG_IRQ_STATUS);
      chk(rd_v & 32'h0000_0008, 32'h0000_0008);
      // legacy interrupt raised, masked and cleared
      wr(pes_pkg::REG_IRQ_CLEAR, 32'h0000_001F);
      wr(pes_pkg::REG_IRQ_ENABLE, 32'h0000_0003);
      int_lvl <= 4'h4;
      repeat (4) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0000_0001);
      rd(pes_pkg::REG_STATUS);
      chk(rd_v & 32'h0000_001E, 32'h0000_0008);
      wr(pes_pkg::REG_IRQ_ENABLE, 32'h0000_0001);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(pes_pkg::REG_IRQ_CLEAR, 32'h0000_001F);
      serr_req <= 1'b1;
      @(posedge core_clk);
      serr_req <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0000_0001);
      rd(pes_pkg::REG_IRQ_STATUS);
      chk(rd_v & 32'h0000_0003, 32'h0000_0001);
      wr(pes_pkg::REG_IRQ_CLEAR, 32'h0000_001F);
      rd(pes_pkg::REG_IRQ_STATUS);
      chk(rd_v, 32'h0000_0000);
      // an empty report vector is refused
      wr(pes_pkg::REG_CMD, 32'h0000_0300);
      rd(pes_pkg::REG_IRQ_STATUS);
      chk(rd_v, 32'h0000_0008);
      wr(pes_pkg::REG_IRQ_CLEAR, 32'h0000_001F);
      // completion timeout, correctable then uncorrectable
      wr(pes_pkg::REG_MSI_CFG, 32'h0001_0A15);
      wr(pes_pkg::REG_PENDING, 32'h0000_0006);
      #1 chk({24'h0, cpl_pending}, 32'h0000_0006);
      rep(7'h01, 3'h1);
      rd(pes_pkg::REG_IRQ_STATUS);
      chk(rd_v & 32'h0000_0010, 32'h0000_0010);
      wr(pes_pkg::REG_MSI_CFG, 32'h0003_0A15);
      wr(pes_pkg::REG_PENDING, 32'h0000_0080);
      rep(7'h02, 3'h7);
      wr(pes_pkg::REG_PENDING, 32'h0000_0000);
      repeat (20) @(posedge core_clk);
      tally_and_finish();
   end
endmodule
